// ### verilog/mcbr_core.sv
// Branch, subroutine call and counter-load execution unit with its APB register file.
`include "mcbr_map.svh"
module mcbr_core #(
    parameter int PC_W = 10,
    parameter int DATA_W = 16,
    parameter int CNT_W = 16,
    parameter int OUT_N = 8,
    localparam int SEL_W = $clog2(OUT_N)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [OUT_N-1:0] drive_out,
    output logic busy
);
    if (PC_W < 5 || PC_W > 10 || DATA_W != 16 || CNT_W != DATA_W) begin : g_check
        $error("mcbr_core: PC_W must be 5..10 and data and counter widths 16");
    end

    mcbr_pkg::mcbr_state_e state;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] aux;
    logic [PC_W-1:0] jr1;
    logic [PC_W-1:0] jr2;
    logic run;
    logic [1:0] bank;
    logic [SEL_W-1:0] bind_first;
    logic [SEL_W-1:0] bind_second;
    logic [3:0][DATA_W-1:0] stat;
    logic [7:0][DATA_W-1:0] alu;
    logic [3:0][CNT_W-1:0] eoc;
    logic [3:0][CNT_W-1:0] cnt;
    logic [15:0] instr;
    logic [11:0] idx;
    logic apb_wr;
    logic [31:0] rd_val;
    logic rd_hit;
    logic ex;
    logic is_jsrr;
    logic is_jtsf;
    logic is_jtsr;
    logic is_ldca;
    logic cond;
    logic [DATA_W-1:0] stat_word;
    logic [2:0] slot;
    mcbr_pkg::mcbr_jsrr_s jf;
    mcbr_pkg::mcbr_ldca_s lf;

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
            input logic [4:0] ofs);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-5){ofs[4]}}, ofs};
        rel_target = base + ext;
    endfunction : rel_target

    // Bit 2 of the result flags a status register, and bits 1:0 pick which of the four.
    function automatic logic [2:0] stat_slot(input logic [11:0] i);
        logic [2:0] res;
        res = 3'h0;
        case (i)
            `MCBR_IDX_STAT_A0: res = 3'h4;
            `MCBR_IDX_STAT_B0: res = 3'h5;
            `MCBR_IDX_STAT_A1: res = 3'h6;
            `MCBR_IDX_STAT_B1: res = 3'h7;
            default: res = 3'h0;
        endcase
        stat_slot = res;
    endfunction : stat_slot

    assign idx = paddr[13:2];
    assign slot = stat_slot(idx);
    assign apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign busy = (state != mcbr_pkg::st_idle);
    assign ex = (state == mcbr_pkg::st_exec);

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (idx)
            `MCBR_IDX_CTRL: begin
                rd_val[`MCBR_CTRL_RUN] = run;
                rd_val[`MCBR_CTRL_BANK +: 2] = bank;
            end
            `MCBR_IDX_STATE: begin
                rd_val[PC_W-1:0] = pc;
                rd_val[`MCBR_STATE_BUSY] = busy;
            end
            `MCBR_IDX_AUX: rd_val[PC_W-1:0] = aux;
            `MCBR_IDX_JR1: rd_val[PC_W-1:0] = jr1;
            `MCBR_IDX_JR2: rd_val[PC_W-1:0] = jr2;
            `MCBR_IDX_BIND: begin
                rd_val[`MCBR_BIND_FIRST +: SEL_W] = bind_first;
                rd_val[`MCBR_BIND_SECOND +: SEL_W] = bind_second;
            end
            `MCBR_IDX_OUT: rd_val[OUT_N-1:0] = drive_out;
            default: begin
                if (slot[2]) begin
                    rd_val[DATA_W-1:0] = stat[slot[1:0]];
                end else if (idx[11:3] == `MCBR_IDX_ALU >> 3) begin
                    rd_val[DATA_W-1:0] = alu[idx[2:0]];
                end else if (idx[11:2] == `MCBR_IDX_EOC >> 2) begin
                    rd_val[CNT_W-1:0] = eoc[idx[1:0]];
                end else if (idx[11:2] == `MCBR_IDX_CNT >> 2) begin
                    rd_val[CNT_W-1:0] = cnt[idx[1:0]];
                end else if (idx[11:10] != `MCBR_CODE_WIN) begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Answer is prepared in the setup cycle so that zero wait states are possible.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? '0 : rd_val;
            pslverr <= !rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            bank <= 2'h0;
        end else if (apb_wr && idx == `MCBR_IDX_CTRL) begin
            run <= pwdata[`MCBR_CTRL_RUN];
            bank <= pwdata[`MCBR_CTRL_BANK +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jr1 <= '0;
            jr2 <= '0;
        end else if (apb_wr && idx == `MCBR_IDX_JR1) begin
            jr1 <= pwdata[PC_W-1:0];
        end else if (apb_wr && idx == `MCBR_IDX_JR2) begin
            jr2 <= pwdata[PC_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bind_first <= SEL_W'(`MCBR_RST_BIND_FIRST);
            bind_second <= SEL_W'(`MCBR_RST_BIND_SECOND);
        end else if (apb_wr && idx == `MCBR_IDX_BIND) begin
            bind_first <= pwdata[`MCBR_BIND_FIRST +: SEL_W];
            bind_second <= pwdata[`MCBR_BIND_SECOND +: SEL_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat <= '0;
        end else if (apb_wr && slot[2]) begin
            stat[slot[1:0]] <= pwdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alu <= '0;
        end else if (apb_wr && idx[11:3] == `MCBR_IDX_ALU >> 3) begin
            alu[idx[2:0]] <= pwdata[DATA_W-1:0];
        end
    end

    mcbr_code_ram #(
        .AW(PC_W),
        .DW(16)
    ) u_code (
        .pclk(pclk),
        .presetn(presetn),
        .we(apb_wr && idx[11:10] == `MCBR_CODE_WIN),
        .waddr(idx[PC_W-1:0]),
        .wdata(pwdata[15:0]),
        .raddr(pc),
        .rdata(instr)
    );

    assign jf = instr;
    assign lf = instr;
    // The absolute call pattern overlaps the status jump space, so it is checked first.
    assign is_jtsf = instr[15:4] == `MCBR_OP_JTSF_HI && instr[2:0] == `MCBR_OP_JTSF_LO;
    assign is_jtsr = instr[15:5] == `MCBR_OP_JTSR;
    assign is_jsrr = jf.opcode == `MCBR_OP_JSRR && !is_jtsf;
    assign is_ldca = lf.opcode == `MCBR_OP_LDCA_HI && lf.tail == `MCBR_OP_LDCA_LO;
    assign stat_word = stat[bank];
    assign cond = (stat_word[jf.sel] == jf.pol);

    // One instruction takes a fetch cycle and an execute cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= mcbr_pkg::st_idle;
            pc <= '0;
            aux <= '0;
        end else begin
            unique case (state)
                mcbr_pkg::st_idle: begin
                    if (run) begin
                        state <= mcbr_pkg::st_fetch;
                    end else if (apb_wr && idx == `MCBR_IDX_STATE) begin
                        pc <= pwdata[PC_W-1:0];
                    end
                end
                mcbr_pkg::st_fetch: state <= mcbr_pkg::st_exec;
                mcbr_pkg::st_exec: begin
                    state <= run ? mcbr_pkg::st_fetch : mcbr_pkg::st_idle;
                    if (is_jtsf) begin
                        aux <= pc;
                        pc <= instr[3] ? jr2 : jr1;
                    end else if (is_jtsr) begin
                        aux <= pc;
                        pc <= rel_target(pc, instr[4:0]);
                    end else if (is_jsrr && cond) begin
                        pc <= rel_target(pc, jf.dest);
                    end else begin
                        pc <= pc + PC_W'(1);
                    end
                end
                default: state <= mcbr_pkg::st_idle;
            endcase
        end
    end

    // A counter climbs by one per cycle and rests once it meets its limit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc <= '0;
            cnt <= '0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (ex && is_ldca && lf.target == 2'(k)) begin
                    eoc[k] <= alu[lf.source];
                end
                if (ex && is_ldca && lf.target == 2'(k) && lf.clear) begin
                    cnt[k] <= '0;
                end else if (cnt[k] != eoc[k]) begin
                    cnt[k] <= cnt[k] + CNT_W'(1);
                end
            end
        end
    end

    mcbr_shortcut #(
        .OUT_N(OUT_N)
    ) u_short (
        .pclk(pclk),
        .presetn(presetn),
        .apply(ex && is_ldca),
        .first_code(lf.sh1),
        .second_code(lf.sh2),
        .first_sel(bind_first),
        .second_sel(bind_second),
        .drive_out(drive_out)
    );

    property p_jsrr_fall;
        @(posedge pclk) disable iff (!presetn)
        ex && is_jsrr && stat_word[jf.sel] != jf.pol |=> pc == $past(pc) + PC_W'(1);
    endproperty
    a_jsrr_fall: assert property (p_jsrr_fall)
        else $error("status jump taken although condition failed");

    property p_jsrr_take;
        @(posedge pclk) disable iff (!presetn)
        ex && is_jsrr && stat[bank][jf.sel] == jf.pol
            |=> pc == rel_target($past(pc), $past(instr[4:0]));
    endproperty
    a_jsrr_take: assert property (p_jsrr_take)
        else $error("status jump target wrong");

    property p_jtsf;
        @(posedge pclk) disable iff (!presetn)
        ex && is_jtsf |=> pc == ($past(instr[3]) ? $past(jr2) : $past(jr1));
    endproperty
    a_jtsf: assert property (p_jtsf)
        else $error("absolute call went to wrong address");

    property p_aux_save;
        @(posedge pclk) disable iff (!presetn)
        ex && (is_jtsf || is_jtsr) |=> aux == $past(pc) ##1 $stable(aux)[*1];
    endproperty
    a_aux_save: assert property (p_aux_save)
        else $error("return address not saved");

    property p_jtsr;
        @(posedge pclk) disable iff (!presetn)
        ex && is_jtsr |=> pc == rel_target($past(pc), $past(instr[4:0]));
    endproperty
    a_jtsr: assert property (p_jtsr)
        else $error("relative call target wrong");

    property p_ldca_eoc;
        @(posedge pclk) disable iff (!presetn)
        ex && is_ldca |=> eoc[$past(instr[7:6])] == $past(alu[instr[5:3]]);
    endproperty
    a_ldca_eoc: assert property (p_ldca_eoc)
        else $error("limit not loaded from ALU register");

    property p_eoc_hold;
        @(posedge pclk) disable iff (!presetn)
        !(ex && is_ldca) |=> $stable(eoc);
    endproperty
    a_eoc_hold: assert property (p_eoc_hold)
        else $error("limit changed without counter load");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        ex && is_ldca && instr[12] |=> cnt[$past(instr[7:6])] == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter not cleared");

    property p_keep_cnt;
        @(posedge pclk) disable iff (!presetn)
        ex && is_ldca && !instr[12] && cnt[instr[7:6]] != '1 && cnt[instr[7:6]] != eoc[instr[7:6]]
            |=> cnt[$past(instr[7:6])] == $past(cnt[instr[7:6]]) + CNT_W'(1);
    endproperty
    a_keep_cnt: assert property (p_keep_cnt)
        else $error("counter disturbed without clear");

    property p_short_on;
        @(posedge pclk) disable iff (!presetn)
        ex && is_ldca && instr[11:10] == 2'h2 && instr[9:8] == 2'h0
            |=> drive_out[$past(bind_first)] == 1'b1;
    endproperty
    a_short_on: assert property (p_short_on)
        else $error("bound output not switched on");

    property p_decode;
        @(posedge pclk) disable iff (!presetn)
        ex |-> $onehot0({is_jsrr, is_jtsf, is_jtsr, is_ldca});
    endproperty
    a_decode: assert property (p_decode)
        else $error("instruction decoded twice");
endmodule : mcbr_core

// ### verilog/mcbr_map.svh
// Register indices, opcode patterns, field positions and reset values of the branch unit.
// Notes on behaviour
// - status jump branches only on condition match
// - taken target is location plus signed offset
// - selector code n picks status bit n
// - status bits come from the four status registers
// - sense 0 wants zero, sense 1 wants one
// - absolute call loads selected jump register
// - both calls save current location in aux
// - relative call always branches by signed offset
// - counter load writes ALU value into target limit
// - counter load source is 3-bit ALU select
// - clear bit zeroes counter, else only limit
// - shortcut codes keep, off, on, invert
// - shortcuts act on outputs bound beforehand
`ifndef MCBR_MAP_SVH
`define MCBR_MAP_SVH
`define MCBR_IDX_CTRL 12'h000
`define MCBR_IDX_STATE 12'h001
`define MCBR_IDX_AUX 12'h002
`define MCBR_IDX_JR1 12'h003
`define MCBR_IDX_JR2 12'h004
`define MCBR_IDX_BIND 12'h005
`define MCBR_IDX_OUT 12'h006
`define MCBR_IDX_ALU 12'h010
`define MCBR_IDX_EOC 12'h020
`define MCBR_IDX_CNT 12'h024
`define MCBR_IDX_STAT_A0 12'h101
`define MCBR_IDX_STAT_B0 12'h102
`define MCBR_IDX_STAT_A1 12'h121
`define MCBR_IDX_STAT_B1 12'h122
`define MCBR_CODE_WIN 2'h1
`define MCBR_CTRL_RUN 0
`define MCBR_CTRL_BANK 1
`define MCBR_STATE_BUSY 16
`define MCBR_BIND_FIRST 0
`define MCBR_BIND_SECOND 4
`define MCBR_OP_JSRR 6'h0e
`define MCBR_OP_JTSF_HI 12'h39b
`define MCBR_OP_JTSF_LO 3'h5
`define MCBR_OP_JTSR 11'h179
`define MCBR_OP_LDCA_HI 3'h5
`define MCBR_OP_LDCA_LO 3'h4
`define MCBR_RST_BIND_FIRST 3'h0
`define MCBR_RST_BIND_SECOND 3'h1
`endif

// ### verilog/mcbr_pkg.sv
// Types shared by the branch unit: states, shortcut codes and instruction layouts.
package mcbr_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_fetch = 2'h1,
        st_exec = 2'h3
    } mcbr_state_e;
    typedef enum logic [1:0] {
        sc_keep = 2'h0,
        sc_off = 2'h1,
        sc_on = 2'h2,
        sc_toggle = 2'h3
    } mcbr_shortcut_e;
    typedef struct packed {
        logic [5:0] opcode;
        logic pol;
        logic [3:0] sel;
        logic [4:0] dest;
    } mcbr_jsrr_s;
    typedef struct packed {
        logic [2:0] opcode;
        logic clear;
        logic [1:0] sh1;
        logic [1:0] sh2;
        logic [1:0] target;
        logic [2:0] source;
        logic [2:0] tail;
    } mcbr_ldca_s;
endpackage : mcbr_pkg

// ### verilog/mcbr_code_ram.sv
// Instruction memory with one write port and a registered read port.
module mcbr_code_ram #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    if (AW < 1 || DW < 1) begin : g_check
        $error("mcbr_code_ram: AW and DW must be positive");
    end

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data come from a flop so a fetch always lands one cycle after its address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : mcbr_code_ram

// ### verilog/mcbr_shortcut.sv
// Output shortcut register: two bound outputs updated by keep, off, on or invert codes.
module mcbr_shortcut #(
    parameter int OUT_N = 8,
    localparam int SEL_W = $clog2(OUT_N)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic apply,
    input wire logic [1:0] first_code,
    input wire logic [1:0] second_code,
    input wire logic [SEL_W-1:0] first_sel,
    input wire logic [SEL_W-1:0] second_sel,
    output logic [OUT_N-1:0] drive_out
);
    if (OUT_N < 2 || OUT_N > 8) begin : g_check
        $error("mcbr_shortcut: OUT_N must lie in 2..8");
    end

    function automatic logic [OUT_N-1:0] apply_code(input logic [OUT_N-1:0] vec,
            input logic [SEL_W-1:0] sel, input logic [1:0] code);
        logic [OUT_N-1:0] res;
        res = vec;
        unique case (mcbr_pkg::mcbr_shortcut_e'(code))
            mcbr_pkg::sc_keep: res[sel] = vec[sel];
            mcbr_pkg::sc_off: res[sel] = 1'b0;
            mcbr_pkg::sc_on: res[sel] = 1'b1;
            mcbr_pkg::sc_toggle: res[sel] = ~vec[sel];
        endcase
        apply_code = res;
    endfunction : apply_code

    // When both slots share one output the second slot is applied last, to the result of the first slot.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_out <= '0;
        end else if (apply) begin
            drive_out <= apply_code(apply_code(drive_out, first_sel, first_code),
                                    second_sel, second_code);
        end
    end
endmodule : mcbr_shortcut

// ### verilog/mcbr_unused_guard.sv
// This file holds no logic; the unit lives in the design files beside it.

// ### bench/mcbr_core_tb_top.sv
// Self-checking bench for the branch, call and counter-load unit driven over APB.
`include "mcbr_map.svh"
module mcbr_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] halt_op = 16'h39e0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] drive_out;
    logic busy;
    int failures = 0;
    int comparisons = 0;

    always #4 pclk = ~pclk;

    mcbr_core dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .drive_out(drive_out),
        .busy(busy)
    );

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    // Each transfer starts one edge after the last one ended, so no signal is assigned twice
    // in one time step.
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge pclk);
        end
        if (n == 100) begin
            failures++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, d, rd, err);
    endtask : wr_reg

    task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        check_val(name, exp, rd);
        check_val({name, "_err"}, 32'h0000_0000, {31'h0, err});
    endtask : rd_chk

    task automatic code(input logic [9:0] addr, input logic [15:0] instr);
        wr_reg(12'h400 | {2'b00, addr}, {16'h0000, instr});
    endtask : code

    // Instructions take two cycles each, so the wait covers every short program here.
    task automatic run_prog(input logic [9:0] start, input logic [1:0] bank);
        int n;
        wr_reg(`MCBR_IDX_STATE, {22'h0, start});
        wr_reg(`MCBR_IDX_CTRL, {29'h0, bank, 1'b1});
        repeat (24) @(posedge pclk);
        wr_reg(`MCBR_IDX_CTRL, {29'h0, bank, 1'b0});
        for (n = 0; n < 50 && busy !== 1'b0; n++) @(posedge pclk);
        check_val("busy", 32'h0000_0000, {31'h0, busy});
    endtask : run_prog

    function automatic logic [15:0] ldca(input logic clr, input logic [1:0] s1,
                                         input logic [1:0] s2, input logic [1:0] tgt,
                                         input logic [2:0] src);
        return {3'b101, clr, s1, s2, tgt, src, 3'b100};
    endfunction : ldca

    task automatic test_reset();
        logic [31:0] rd;
        logic err;
        rd_chk("ctrl", `MCBR_IDX_CTRL, 32'h0000_0000);
        rd_chk("bind", `MCBR_IDX_BIND, 32'h0000_0010);
        rd_chk("out", `MCBR_IDX_OUT, 32'h0000_0000);
        apb(1'b0, 12'h300, 32'h0000_0000, rd, err);
        check_val("unmapped_err", 32'h0000_0001, {31'h0, err});
        check_val("unmapped_data", 32'h0000_0000, rd);
        wr_reg(`MCBR_IDX_AUX, 32'h0000_0155);
        rd_chk("aux_ro", `MCBR_IDX_AUX, 32'h0000_0000);
        $display("test reset done");
    endtask : test_reset

    // Bit 15 stays clear in every bank so the halt loop always holds its own location.
    task automatic test_status_jump();
        logic [15:0] pat [4];
        logic [11:0] sidx [4];
        logic [4:0] ofs;
        logic [9:0] loc;
        logic [9:0] tgt;
        logic [9:0] exp;
        logic pol;
        logic [1:0] bank;
        pat = '{16'h5a3c, 16'h3c5a, 16'h0ff0, 16'h7001};
        sidx = '{`MCBR_IDX_STAT_A0, `MCBR_IDX_STAT_B0, `MCBR_IDX_STAT_A1, `MCBR_IDX_STAT_B1};
        for (int b = 0; b < 4; b++) wr_reg(sidx[b], {16'h0000, pat[b]});
        for (int s = 0; s < 16; s++) begin
            bank = s[1:0];
            pol = s[2] ^ s[0];
            ofs = s[0] ? 5'h10 : 5'h0f;
            loc = 10'h100;
            tgt = loc + {{5{ofs[4]}}, ofs};
            code(loc, {6'b001110, pol, s[3:0], ofs});
            code(loc + 10'h001, halt_op);
            code(tgt, halt_op);
            run_prog(loc, bank);
            exp = (pat[bank][s] == pol) ? tgt : loc + 10'h001;
            rd_chk("jsrr_pc", `MCBR_IDX_STATE, {22'h0, exp});
        end
        $display("test status jump done");
    endtask : test_status_jump

    task automatic test_calls();
        logic [9:0] loc;
        logic [9:0] tgt;
        logic [4:0] ofs;
        wr_reg(`MCBR_IDX_JR1, 32'h0000_02a0);
        wr_reg(`MCBR_IDX_JR2, 32'h0000_0155);
        for (int k = 0; k < 2; k++) begin
            loc = 10'h050 + 10'(3 * k);
            tgt = k[0] ? 10'h155 : 10'h2a0;
            code(loc, k[0] ? 16'h39bd : 16'h39b5);
            code(tgt, halt_op);
            run_prog(loc, 2'h0);
            rd_chk("jtsf_pc", `MCBR_IDX_STATE, {22'h0, tgt});
            rd_chk("jtsf_aux", `MCBR_IDX_AUX, {22'h0, loc});
        end
        for (int k = 0; k < 2; k++) begin
            loc = 10'h200 + 10'(5 * k);
            ofs = k[0] ? 5'h0f : 5'h10;
            tgt = loc + {{5{ofs[4]}}, ofs};
            code(loc, 16'h2f20 | {11'h000, ofs});
            code(tgt, halt_op);
            run_prog(loc, 2'h0);
            rd_chk("jtsr_pc", `MCBR_IDX_STATE, {22'h0, tgt});
            rd_chk("jtsr_aux", `MCBR_IDX_AUX, {22'h0, loc});
        end
        $display("test calls done");
    endtask : test_calls

    // Small limits let every counter reach its limit and hold before it is read.
    task automatic test_ldca();
        logic [15:0] lim [4];
        logic [2:0] src [4];
        lim = '{16'h0003, 16'h0005, 16'h0007, 16'h0009};
        src = '{3'h1, 3'h2, 3'h3, 3'h7};
        wr_reg(`MCBR_IDX_BIND, 32'h0000_0053);
        for (int i = 0; i < 4; i++) wr_reg(`MCBR_IDX_ALU + 12'(src[i]), {16'h0000, lim[i]});
        code(10'h300, ldca(1'b0, 2'h2, 2'h3, 2'h0, 3'h1));
        code(10'h301, ldca(1'b1, 2'h3, 2'h0, 2'h1, 3'h2));
        code(10'h302, ldca(1'b0, 2'h0, 2'h1, 2'h2, 3'h3));
        code(10'h303, ldca(1'b1, 2'h2, 2'h0, 2'h3, 3'h7));
        code(10'h304, halt_op);
        run_prog(10'h300, 2'h0);
        check_val("drive_out", 32'h0000_0008, {24'h0, drive_out});
        rd_chk("out_reg", `MCBR_IDX_OUT, 32'h0000_0008);
        for (int i = 0; i < 4; i++) begin
            rd_chk("eoc", `MCBR_IDX_EOC + 12'(i), {16'h0000, lim[i]});
            rd_chk("cnt", `MCBR_IDX_CNT + 12'(i), {16'h0000, lim[i]});
        end
        $display("test counter load done");
    endtask : test_ldca

    // Both counters share one latency, so only their gap is judged, not the exact moment.
    task automatic test_clear();
        logic [31:0] c1;
        logic [31:0] c2;
        logic [31:0] gap;
        logic err;
        wr_reg(`MCBR_IDX_ALU, 32'h0000_7fff);
        code(10'h310, ldca(1'b0, 2'h0, 2'h0, 2'h0, 3'h0));
        code(10'h311, ldca(1'b1, 2'h0, 2'h0, 2'h1, 3'h0));
        code(10'h312, ldca(1'b0, 2'h0, 2'h0, 2'h0, 3'h0));
        code(10'h313, halt_op);
        run_prog(10'h310, 2'h0);
        apb(1'b0, `MCBR_IDX_CNT, 32'h0000_0000, c1, err);
        apb(1'b0, `MCBR_IDX_CNT + 12'h001, 32'h0000_0000, c2, err);
        gap = c1 - c2;
        check_val("clear_gap", 32'h0000_0001, {31'h0, gap >= 2 && gap <= 4});
        check_val("keep_out", 32'h0000_0008, {24'h0, drive_out});
        $display("test counter clear done");
    endtask : test_clear

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_status_jump();
        test_calls();
        test_ldca();
        test_clear();
        give_verdict();
    end
endmodule : mcbr_core_tb_top
